// file: hw/pss_capture.sv
// Precise sampling engine: counters, event selectors, record capture and record writer.
// Notes on behaviour
// - Only counters zero to three can produce sample records; four to seven never.
// - Record layout is mode independent; capability bit 2 reports wide storage.
// - Record of 8-byte slots: flags, next ip, registers, overflow at 90H, abort B8H.
// - Slot B0H holds the retired instruction address that caused the sample.
// - Slots 98H, A0H, A8H carry address, source and latency in core cycles.
// - Memory-address profiling covers both loads and stores.
// - Profiling works on any sampling counter with a supported memory event.
// - Overflow of a sampling-enabled counter starts a sample record when capture is idle; otherwise it is dropped.
// - On overflow the retiring memory uop address and status are latched.
// - A sampling enable bit makes a sampling counter and enables address profiling.
// - With profiling on, slots 98H, A0H and A8H get memory reference data.
// - For stores, status bit 0 is the L1 hit flag; other bits zero.
module pss_capture #(
    parameter int CTR_W = 32
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [7:0] count_event_i,
    input wire pss_pkg::pss_retire_s retire_i,
    output pss_pkg::pss_memwr_s memwr_o,
    input wire logic mem_ready_i,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic int slot(input logic [7:0] ofs);
        return int'(ofs[7:3]);
    endfunction

    // Selector and counter windows are eight words each, picked by address bits 7:5.
    function automatic logic is_evsel(input logic [7:0] a);
        return a[7:5] == pss_pkg::REG_EVENT_SEL_BASE[7:5];
    endfunction

    function automatic logic is_ctr(input logic [7:0] a);
        return a[7:5] == pss_pkg::REG_COUNTER_BASE[7:5];
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [3:0] samp_en_q, samp_en_d;
    logic [1:0] irq_stat_q, irq_stat_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic [63:0] base_q, base_d;
    logic [31:0] index_q, index_d;
    logic [7:0] glob_q, glob_d;
    // Counters four to seven count and flag overflow but can never sample.
    logic [31:0] evsel_q [pss_pkg::TOTAL_COUNTERS];
    logic [31:0] evsel_d [pss_pkg::TOTAL_COUNTERS];
    logic [CTR_W-1:0] ctr_q [pss_pkg::TOTAL_COUNTERS];
    logic [CTR_W-1:0] ctr_d [pss_pkg::TOTAL_COUNTERS];
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic trigger;
    logic drop;
    logic [7:0] ovf_now;

    pss_pkg::pss_cap_state_e state_q, state_d;
    logic [4:0] word_q, word_d;
    // A whole record is held, so a stalled writer never holds up the core side.
    logic [63:0] rec_q [pss_pkg::REC_WORDS];
    logic [63:0] rec_d [pss_pkg::REC_WORDS];
    pss_pkg::pss_memwr_s mem_q, mem_d;
    logic rec_done;

    // ------------------------------------------------------------------
    // Register bus, counters and interrupt
    // ------------------------------------------------------------------
    // A request is answered one cycle after it is seen: waitrequest drops for exactly one
    // cycle; the read data loads on the edge that drops it, the write and the read-clear on the edge that ends it.
    always_comb begin
        logic acc;
        logic [31:0] rv;
        logic [31:0] mv;
        int idx;
        acc = 1'b0;
        rv = pss_pkg::RST_WORD;
        mv = pss_pkg::RST_WORD;
        idx = 0;
        samp_en_d = samp_en_q;
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        base_d = base_q;
        index_d = index_q;
        glob_d = glob_q;
        evsel_d = evsel_q;
        ctr_d = ctr_q;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        acc = (avs_read_i || avs_write_i) && !wait_q;
        idx = int'(avs_address_i[4:2]);

        // The read mux runs every cycle; only the first cycle of a request loads it.
        case (avs_address_i)
            pss_pkg::REG_SAMPLING_ENABLE: rv = {28'h000_0000, samp_en_q};
            pss_pkg::REG_IRQ_STATUS: rv = {30'h0000_0000, irq_stat_q};
            pss_pkg::REG_IRQ_MASK: rv = {30'h0000_0000, irq_mask_q};
            pss_pkg::REG_BUF_BASE_LO: rv = base_q[31:0];
            pss_pkg::REG_BUF_BASE_HI: rv = base_q[63:32];
            pss_pkg::REG_BUF_INDEX: rv = index_q;
            pss_pkg::REG_CAPS: rv = 32'(1) << pss_pkg::CAPS_WIDE_STORAGE_BIT;
            pss_pkg::REG_GLOBAL_OVF: rv = {24'h00_0000, glob_q};
            default: begin
                if (is_evsel(avs_address_i)) begin
                    rv = evsel_q[idx];
                end else if (is_ctr(avs_address_i)) begin
                    rv = 32'(ctr_q[idx]);
                end
            end
        endcase

        if ((avs_read_i || avs_write_i) && wait_q) begin
            wait_d = 1'b0;
            rdata_d = avs_read_i ? rv : pss_pkg::RST_WORD;
        end

        // A held request meets the accept term once, so one read clears the status once.
        // An event in that same cycle is merged in below, so the set wins.
        if (acc && avs_read_i && avs_address_i == pss_pkg::REG_IRQ_STATUS) begin
            irq_stat_d = 2'b00;
        end
        if (acc && avs_write_i) begin
            case (avs_address_i)
                pss_pkg::REG_SAMPLING_ENABLE: begin
                    // Only four enable bits exist, so counters four to seven cannot sample.
                    mv = merge_bytes(32'(samp_en_q), avs_writedata_i, avs_byteenable_i);
                    samp_en_d = mv[3:0];
                end
                pss_pkg::REG_IRQ_MASK: begin
                    mv = merge_bytes(32'(irq_mask_q), avs_writedata_i, avs_byteenable_i);
                    irq_mask_d = mv[1:0];
                end
                pss_pkg::REG_BUF_BASE_LO: begin
                    base_d[31:0] = merge_bytes(base_q[31:0], avs_writedata_i, avs_byteenable_i);
                end
                pss_pkg::REG_BUF_BASE_HI: begin
                    base_d[63:32] = merge_bytes(base_q[63:32], avs_writedata_i,
                                                avs_byteenable_i);
                end
                pss_pkg::REG_BUF_INDEX: begin
                    index_d = merge_bytes(index_q, avs_writedata_i, avs_byteenable_i);
                end
                pss_pkg::REG_GLOBAL_OVF: begin
                    glob_d = glob_q & ~(avs_writedata_i[7:0] & {8{avs_byteenable_i[0]}});
                end
                default: begin
                    if (is_evsel(avs_address_i)) begin
                        evsel_d[idx] = merge_bytes(evsel_q[idx], avs_writedata_i,
                                                   avs_byteenable_i);
                    end else if (is_ctr(avs_address_i)) begin
                        ctr_d[idx] = CTR_W'(merge_bytes(32'(ctr_q[idx]), avs_writedata_i,
                                                        avs_byteenable_i));
                    end
                end
            endcase
        end

        // Counting follows the software write so an event in the same cycle is not lost.
        // A counter overflows when an increment wraps it to zero, and then counts on.
        ovf_now = 8'h00;
        for (int c = 0; c < pss_pkg::TOTAL_COUNTERS; c++) begin
            if (evsel_q[c][pss_pkg::EVSEL_ENABLE_BIT] && count_event_i[c]) begin
                ctr_d[c] = ctr_d[c] + CTR_W'(1);
                ovf_now[c] = (ctr_d[c] == '0);
            end
        end
        glob_d = glob_d | ovf_now;

        // Any overflow of an enabled sampling counter asks for a record.
        trigger = |(ovf_now[pss_pkg::SAMPLE_COUNTERS-1:0] & samp_en_q);
        // A trigger in the done cycle is dropped too: a new snapshot waits for idle.
        drop = trigger && (state_q != pss_pkg::CAP_IDLE);
        // The index has no bound; buffer wrap and thresholds belong to software.
        if (rec_done) begin
            index_d = index_d + 32'd1;
        end
        irq_stat_d[pss_pkg::IRQ_RECORD_DONE_BIT] = irq_stat_d[pss_pkg::IRQ_RECORD_DONE_BIT]
                                                   | rec_done;
        irq_stat_d[pss_pkg::IRQ_SAMPLE_DROP_BIT] = irq_stat_d[pss_pkg::IRQ_SAMPLE_DROP_BIT]
                                                   | drop;
        // Built from the next status, so the interrupt rises with its status bit.
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            samp_en_q <= 4'h0;
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
            base_q <= pss_pkg::RST_DWORD;
            index_q <= pss_pkg::RST_WORD;
            glob_q <= 8'h00;
            for (int c = 0; c < pss_pkg::TOTAL_COUNTERS; c++) begin
                evsel_q[c] <= pss_pkg::RST_WORD;
                ctr_q[c] <= '0;
            end
            wait_q <= 1'b1;
            rdata_q <= pss_pkg::RST_WORD;
            irq_q <= 1'b0;
        end else begin
            samp_en_q <= samp_en_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            base_q <= base_d;
            index_q <= index_d;
            glob_q <= glob_d;
            evsel_q <= evsel_d;
            ctr_q <= ctr_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Record capture and writer
    // ------------------------------------------------------------------
    always_comb begin
        logic [63:0] status;
        state_d = state_q;
        word_d = word_q;
        rec_d = rec_q;
        mem_d = mem_q;
        rec_done = 1'b0;
        status = pss_pkg::RST_DWORD;
        case (state_q)
            pss_pkg::CAP_IDLE: begin
                if (trigger) begin
                    // The snapshot is taken in the overflow cycle, so the record is the
                    // same in every operating mode and later retirement cannot alter it.
                    for (int w = 0; w < pss_pkg::REC_WORDS; w++) begin
                        rec_d[w] = pss_pkg::RST_DWORD;
                    end
                    rec_d[slot(pss_pkg::OFS_FLAGS)] = retire_i.flags;
                    rec_d[slot(pss_pkg::OFS_NEXT_IP)] = retire_i.next_ip;
                    for (int g = 0; g < 16; g++) begin
                        rec_d[slot(pss_pkg::OFS_GPR0) + g] = retire_i.gpr[g];
                    end
                    rec_d[slot(pss_pkg::OFS_GLOBAL_OVF)] = {56'h0, glob_d};
                    rec_d[slot(pss_pkg::OFS_EVENTING_IP)] = retire_i.eventing_instr_addr;
                    rec_d[slot(pss_pkg::OFS_ABORT_INFO)] = pss_pkg::RST_DWORD;
                    if (retire_i.mem_valid) begin
                        // Loads and stores alike; a non-memory event leaves the slots zero.
                        if (retire_i.mem_is_store) begin
                            status[pss_pkg::STORE_L1_HIT_BIT] = retire_i.l1_store_hit;
                        end else begin
                            status = retire_i.data_source;
                        end
                        rec_d[slot(pss_pkg::OFS_LIN_ADDR)] =
                            retire_i.lin_addr;
                        rec_d[slot(pss_pkg::OFS_DATA_STATUS)] = status;
                        rec_d[slot(pss_pkg::OFS_LATENCY)] = retire_i.latency;
                    end
                    word_d = 5'd0;
                    state_d = pss_pkg::CAP_WRITE;
                end
            end
            pss_pkg::CAP_WRITE: begin
                // Valid drops for one cycle after each accepted word but the last: this costs bandwidth
                // but gives every word a full cycle to settle before it is offered.
                if (mem_q.valid && mem_ready_i) begin
                    mem_d.valid = 1'b0;
                    if (word_q == 5'(pss_pkg::REC_WORDS - 1)) begin
                        state_d = pss_pkg::CAP_DONE;
                    end else begin
                        word_d = word_q + 5'd1;
                    end
                end else begin
                    mem_d.valid = 1'b1;
                    // The address uses the live base and index, so software must not move
                    // the buffer while a record is in flight.
                    mem_d.addr = base_q + 64'(index_q) * 64'(pss_pkg::REC_BYTES)
                                 + {56'h0, word_q, 3'b000};
                    mem_d.data = rec_q[word_q];
                end
            end
            pss_pkg::CAP_DONE: begin
                // One spare cycle lets the index and the status bit move together.
                rec_done = 1'b1;
                state_d = pss_pkg::CAP_IDLE;
            end
            default: begin
                state_d = pss_pkg::CAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= pss_pkg::CAP_IDLE;
            word_q <= 5'd0;
            for (int w = 0; w < pss_pkg::REC_WORDS; w++) begin
                rec_q[w] <= pss_pkg::RST_DWORD;
            end
            mem_q <= '0;
        end else begin
            state_q <= state_d;
            word_q <= word_d;
            rec_q <= rec_d;
            mem_q <= mem_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a register
    // ------------------------------------------------------------------
    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign memwr_o = mem_q;
    assign irq_o = irq_q;

endmodule

// file: hw/pss_pkg.sv
// Package of constants and carrier types for the precise sampling record capture block.
package pss_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the Avalon-MM slave
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_SAMPLING_ENABLE = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_BUF_BASE_LO = 8'h0C;
    localparam logic [7:0] REG_BUF_BASE_HI = 8'h10;
    localparam logic [7:0] REG_BUF_INDEX = 8'h14;
    localparam logic [7:0] REG_CAPS = 8'h18;
    localparam logic [7:0] REG_GLOBAL_OVF = 8'h1C;
    localparam logic [7:0] REG_EVENT_SEL_BASE = 8'h20;
    localparam logic [7:0] REG_COUNTER_BASE = 8'h40;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int EVSEL_ENABLE_BIT = 22;
    localparam int CAPS_WIDE_STORAGE_BIT = 2;
    localparam int IRQ_RECORD_DONE_BIT = 0;
    localparam int IRQ_SAMPLE_DROP_BIT = 1;
    localparam int STORE_L1_HIT_BIT = 0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [63:0] RST_DWORD = 64'h0000_0000_0000_0000;

    // ------------------------------------------------------------------
    // Record layout, byte offsets of 8-byte slots
    // ------------------------------------------------------------------
    localparam int REC_WORDS = 24;
    localparam int REC_BYTES = 192;
    localparam int SAMPLE_COUNTERS = 4;
    localparam int TOTAL_COUNTERS = 8;
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_NEXT_IP = 8'h08;
    localparam logic [7:0] OFS_GPR0 = 8'h10;
    localparam logic [7:0] OFS_GLOBAL_OVF = 8'h90;
    localparam logic [7:0] OFS_LIN_ADDR = 8'h98;
    localparam logic [7:0] OFS_DATA_STATUS = 8'hA0;
    localparam logic [7:0] OFS_LATENCY = 8'hA8;
    localparam logic [7:0] OFS_EVENTING_IP = 8'hB0;
    localparam logic [7:0] OFS_ABORT_INFO = 8'hB8;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [63:0] flags;
        logic [63:0] next_ip;
        logic [63:0] eventing_instr_addr;
        logic [15:0][63:0] gpr;
        logic mem_valid;
        logic mem_is_store;
        logic l1_store_hit;
        logic [63:0] lin_addr;
        logic [63:0] data_source;
        logic [63:0] latency;
    } pss_retire_s;

    typedef struct packed {
        logic valid;
        logic [63:0] addr;
        logic [63:0] data;
    } pss_memwr_s;

    typedef enum logic [2:0] {
        CAP_IDLE = 3'b001,
        CAP_WRITE = 3'b010,
        CAP_DONE = 3'b100
    } pss_cap_state_e;

endpackage

// file: verification/pss_capture_sva.sv
// Checker of register handshake and record writer timing of the sampling capture block.
module pss_capture_sva #(
    parameter int CTR_W = 32
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire pss_pkg::pss_memwr_s memwr_o,
    input wire logic mem_ready_i,
    input wire logic irq_o
);
    // ----
    // Word position inside the record being written
    // ----
    // The port shows no record boundary, so accepted words are counted modulo 24.
    logic [4:0] wcnt_q;
    logic [4:0] wcnt_d;
    logic acc;
    assign acc = memwr_o.valid && mem_ready_i;
    always_comb begin
        wcnt_d = wcnt_q;
        if (acc) begin
            wcnt_d = (wcnt_q == 5'h17) ? 5'h00 : wcnt_q + 5'h01;
        end
    end
    always_ff @(posedge core_clk_i) begin
        wcnt_q <= reset_i ? 5'h00 : wcnt_d;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // ----
    // Properties
    // ----
    a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("waitrequest not low one cycle after request");
    a_wait_low_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_wait_has_cause: assert property (!avs_waitrequest_o
        |-> $past(avs_read_i || avs_write_i) && $past(avs_waitrequest_o))
        else $error("waitrequest low without a pending request");
    a_addr_holds: assert property (memwr_o.valid && !mem_ready_i
        |=> memwr_o.valid && $stable(memwr_o.addr)) else $error("record word address moved");
    a_data_holds: assert property (memwr_o.valid && !mem_ready_i
        |=> $stable(memwr_o.data)) else $error("record word data moved while stalled");
    a_word_spacing: assert property (acc && wcnt_q != 5'h17
        |=> !memwr_o.valid ##1 memwr_o.valid) else $error("record word spacing wrong");
    a_record_tail: assert property (acc && wcnt_q == 5'h17
        |=> !memwr_o.valid [*2]) else $error("record did not end after 24 words");
    a_addr_ascends: assert property (acc && wcnt_q != 5'h17 ##2 memwr_o.valid
        |-> memwr_o.addr == $past(memwr_o.addr, 2) + 64'h8) else $error("address not +8");
    c_record_end: cover property (acc && wcnt_q == 5'h17);
    c_stall: cover property (memwr_o.valid && !mem_ready_i);
    c_irq: cover property ($rose(irq_o));
endmodule

bind pss_capture pss_capture_sva #(.CTR_W(CTR_W)) u_sva (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .memwr_o(memwr_o), .mem_ready_i(mem_ready_i),
    .irq_o(irq_o));

// file: verification/test_pss_capture.sv
// Self-checking bench for the precise sampling record capture block.
module test_pss_capture;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] count_event_i = 8'h00;
    pss_pkg::pss_retire_s retire_i = '0;
    pss_pkg::pss_memwr_s memwr_o;
    logic mem_ready_i = 1'b0;
    logic irq_o;
    logic stall_en = 1'b0;
    int err_total = 0;
    int compares = 0;
    logic [63:0] got_addr[$];
    logic [63:0] got_data[$];
    logic [63:0] base;
    logic [31:0] rd;
    logic [31:0] idx;
    pss_pkg::pss_retire_s r;

    always #20 core_clk_i = ~core_clk_i;

    pss_capture DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .count_event_i(count_event_i),
        .retire_i(retire_i), .memwr_o(memwr_o), .mem_ready_i(mem_ready_i), .irq_o(irq_o));

    // Random stalls keep the writer holding words across several edges.
    always @(posedge core_clk_i) begin
        mem_ready_i <= stall_en ? 1'($urandom) : 1'b1;
        if (memwr_o.valid === 1'b1 && mem_ready_i === 1'b1) begin
            got_addr.push_back(memwr_o.addr);
            got_data.push_back(memwr_o.data);
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        avs_address_i <= a;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        do begin
            @(posedge core_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(64'(rd), 64'(exp));
    endtask

    function automatic pss_pkg::pss_retire_s rnd_retire();
        logic [1439:0] raw;
        for (int k = 0; k < 45; k++) raw[k*32 +: 32] = $urandom;
        return pss_pkg::pss_retire_s'(raw[$bits(pss_pkg::pss_retire_s)-1:0]);
    endfunction

    function automatic logic [63:0] exp_word(input int w, input pss_pkg::pss_retire_s s,
        input logic [7:0] ovf);
        logic [63:0] v;
        v = 64'h0;
        if (w == 0) v = s.flags;
        else if (w == 1) v = s.next_ip;
        else if (w < 18) v = s.gpr[w-2];
        else if (w == 18) v = {56'h0, ovf};
        else if (s.mem_valid && w == 19) v = s.lin_addr;
        else if (s.mem_valid && w == 20 && s.mem_is_store) v = {63'h0, s.l1_store_hit};
        else if (s.mem_valid && w == 20) v = s.data_source;
        else if (s.mem_valid && w == 21) v = s.latency;
        else if (w == 22) v = s.eventing_instr_addr;
        return v;
    endfunction

    task automatic rec_chk(input logic [7:0] ovf, input logic [31:0] ix);
        int n;
        n = 0;
        while (got_addr.size() < 24 && n < 500) begin
            @(posedge core_clk_i);
            n++;
        end
        repeat (4) @(posedge core_clk_i);
        chk(64'(got_addr.size()), 64'h18);
        for (int w = 0; w < 24 && got_addr.size() > 0; w++) begin
            chk(got_addr.pop_front(), base + 64'(ix) * 64'hC0 + 64'(8 * w));
            chk(got_data.pop_front(), exp_word(w, r, ovf));
        end
        rdchk(pss_pkg::REG_BUF_INDEX, ix + 32'h1);
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        void'($urandom(59));
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        bus(1'b1, pss_pkg::REG_CAPS, 32'h0000_0000, 4'hF);
        bus(1'b0, pss_pkg::REG_CAPS, 32'h0000_0000, 4'hF);
        chk(64'(rd[pss_pkg::CAPS_WIDE_STORAGE_BIT]), 64'h1);
        rdchk(pss_pkg::REG_SAMPLING_ENABLE, 32'h0000_0000);
        bus(1'b1, 8'h60, 32'hFFFF_FFFF, 4'hF);
        rdchk(8'h60, 32'h0000_0000);
        bus(1'b1, pss_pkg::REG_EVENT_SEL_BASE, 32'hFFFF_FFFF, 4'h1);
        rdchk(pss_pkg::REG_EVENT_SEL_BASE, 32'h0000_00FF);
        base = {32'($urandom), 32'($urandom)} & 64'hFFFF_FFFF_FFFF_FFF8;
        idx = 32'($urandom % 8);
        bus(1'b1, pss_pkg::REG_BUF_BASE_LO, base[31:0], 4'hF);
        bus(1'b1, pss_pkg::REG_BUF_BASE_HI, base[63:32], 4'hF);
        bus(1'b1, pss_pkg::REG_BUF_INDEX, idx, 4'hF);
        bus(1'b1, pss_pkg::REG_IRQ_MASK, 32'h0000_0001, 4'hF);
        stall_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            r = rnd_retire();
            // Corner cases: a load, a store, a non-memory event, then a store again.
            r.mem_valid = 1'(i != 2);
            r.mem_is_store = 1'(i % 2);
            retire_i <= r;
            bus(1'b1, pss_pkg::REG_GLOBAL_OVF, 32'h0000_00FF, 4'hF);
            bus(1'b1, 8'(pss_pkg::REG_EVENT_SEL_BASE + 4 * i), 32'h0040_0000, 4'hF);
            bus(1'b1, 8'(pss_pkg::REG_COUNTER_BASE + 4 * i), 32'hFFFF_FFFF, 4'hF);
            bus(1'b1, pss_pkg::REG_SAMPLING_ENABLE, 32'(1 << i), 4'hF);
            count_event_i <= 8'(1 << i);
            @(posedge core_clk_i);
            count_event_i <= 8'h00;
            rec_chk(8'(1 << i), idx + 32'(i));
            chk(64'(irq_o), 64'h1);
            rdchk(pss_pkg::REG_IRQ_STATUS, 32'h0000_0001);
            rdchk(pss_pkg::REG_IRQ_STATUS, 32'h0000_0000);
            chk(64'(irq_o), 64'h0);
            bus(1'b1, pss_pkg::REG_SAMPLING_ENABLE, 32'h0000_0000, 4'hF);
        end
        // Counter four cannot sample and counter zero is not sampling-enabled: no record may appear.
        bus(1'b1, pss_pkg::REG_GLOBAL_OVF, 32'h0000_00FF, 4'hF);
        bus(1'b1, 8'(pss_pkg::REG_EVENT_SEL_BASE + 16), 32'h0040_0000, 4'hF);
        bus(1'b1, 8'(pss_pkg::REG_COUNTER_BASE + 16), 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, pss_pkg::REG_COUNTER_BASE, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, pss_pkg::REG_SAMPLING_ENABLE, 32'h0000_00F0, 4'hF);
        rdchk(pss_pkg::REG_SAMPLING_ENABLE, 32'h0000_0000);
        count_event_i <= 8'h11;
        @(posedge core_clk_i);
        count_event_i <= 8'h00;
        repeat (40) @(posedge core_clk_i);
        chk(64'(got_addr.size()), 64'h0);
        rdchk(pss_pkg::REG_GLOBAL_OVF, 32'h0000_0011);
        // Second overflow while the writer is busy is dropped; the interrupt stays masked.
        bus(1'b1, pss_pkg::REG_GLOBAL_OVF, 32'h0000_00FF, 4'hF);
        bus(1'b1, pss_pkg::REG_IRQ_MASK, 32'h0000_0000, 4'hF);
        bus(1'b1, pss_pkg::REG_COUNTER_BASE, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, 8'(pss_pkg::REG_COUNTER_BASE + 4), 32'hFFFF_FFFE, 4'hF);
        bus(1'b1, pss_pkg::REG_SAMPLING_ENABLE, 32'h0000_0003, 4'hF);
        count_event_i <= 8'h03;
        repeat (2) @(posedge core_clk_i);
        count_event_i <= 8'h00;
        rec_chk(8'h01, idx + 32'h4);
        chk(64'(irq_o), 64'h0);
        rdchk(pss_pkg::REG_IRQ_STATUS, 32'h0000_0003);
        close_out();
    end
endmodule
